// file: hdl/dmadr_defs.vh
// Summary of operation
// - Provide 512 bytes RAM: 256 internal, 256 on-chip external.
// - Lower 128 internal bytes answer both direct and indirect accesses.
// - Locations 0x00-0x1F form four banks of eight working registers.
// - One bank active, chosen by program status word bits 3 and 4.
// - Indirect pointers come from working register 0 or 1 of active bank.
// - Above 0x7F: direct hits special-function space, indirect hits upper RAM.
// - Bytes 0x20-0x2F give 128 bits; bit address = 8*offset + position.
// - Bit versus byte access chosen by operand type, not address.
// - Push writes at stack pointer plus one, then increments pointer.
// - Reset loads stack pointer with 0x07.
// - Stack pointer reaches all 256 internal bytes.
// - External moves reach on-chip external RAM in on-chip mode, or in split modes with address high byte zero, unless set for flash writing.
// - 16-bit external move uses data pointer; high and low bytes accessible.
// - 8-bit external move address is page select high, register 0/1 low.
// - Interface claims pins only during off-chip external move.
// - During off-chip move, drivers of input pins are disabled.
// - Open-drain or push-pull mode stays with port output-mode registers.
// - Multiplexed or non-multiplexed address/data arrangement is selectable.
// - Four memory modes: on-chip, split, split banked, off-chip.
// - Page select is eight bits, resets to zero, picks 256-byte page.
`ifndef DMADR_DEFS_VH
`define DMADR_DEFS_VH
`define DMADR_SP_RESET     8'h07
`define DMADR_PAGE_RESET   8'h00
`define DMADR_DATA_POINTER_RESET   16'h0000
`define DMADR_BIT_BASE     8'h20
`define DMADR_UPPER_BIT    7
`define DMADR_PSW_RS_LO    3
`define DMADR_PSW_RS_HI    4
`define DMADR_MODE_ONCHIP  2'h0
`define DMADR_MODE_SPLIT   2'h1
`define DMADR_MODE_SPLITB  2'h2
`define DMADR_MODE_OFFCHIP 2'h3
`define DMADR_RAM_DEPTH    256
`endif

// file: hdl/dmadr_ram.v
`include "dmadr_defs.vh"
module dmadr_ram
(
    // clock
    input  wire       i_clock,
    // write port
    input  wire       i_we,
    input  wire [7:0] i_waddr,
    input  wire [7:0] i_wdata,
    // read port
    input  wire [7:0] i_raddr,
    output reg  [7:0] o_rdata
);
    reg [7:0] mem [0:`DMADR_RAM_DEPTH-1];

    // no reset on storage: ram contents are undefined at power up
    always @(posedge i_clock)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // dmadr_ram

// file: hdl/dmadr_top.v
`include "dmadr_defs.vh"
module dmadr_top
(
    // clock and reset
    input  wire        i_clock,
    input  wire        i_rst,
    // core configuration
    input  wire [7:0]  i_program_status_word,
    input  wire        i_flash_write_enable,
    // internal data access
    input  wire        i_int_req,
    input  wire        i_int_write,
    input  wire        i_int_indirect,
    input  wire        i_int_is_bit,
    input  wire        i_int_use_reg,
    input  wire [2:0]  i_int_reg_num,
    input  wire        i_int_ptr_sel,
    input  wire [7:0]  i_int_addr,
    input  wire [7:0]  i_int_wdata,
    input  wire        i_int_bit_wdata,
    output reg  [7:0]  o_int_rdata,
    output reg         o_int_bit_rdata,
    output reg         o_int_valid,
    // special-function register pass-through
    output reg         o_sfr_req,
    output reg         o_sfr_write,
    output reg  [7:0]  o_sfr_addr,
    output reg  [7:0]  o_sfr_wdata,
    // stack
    input  wire        i_push,
    input  wire [7:0]  i_push_data,
    input  wire        i_sp_write,
    input  wire [7:0]  i_sp_wdata,
    output reg  [7:0]  o_stack_pointer,
    // data pointer and page select
    input  wire        i_dph_write,
    input  wire        i_dpl_write,
    input  wire        i_page_write,
    input  wire [7:0]  i_sfr_wdata,
    output reg  [7:0]  o_data_pointer_high,
    output reg  [7:0]  o_data_pointer_low,
    output reg  [7:0]  o_page_select_field,
    // external move
    input  wire        i_xmov_req,
    input  wire        i_xmov_write,
    input  wire        i_xmov_wide,
    input  wire        i_xmov_ptr_sel,
    input  wire [7:0]  i_xmov_wdata,
    input  wire        i_xmov_offchip_done,
    input  wire [7:0]  i_xmov_offchip_rdata,
    output reg  [7:0]  o_xmov_rdata,
    output reg         o_xmov_valid,
    output reg         o_flash_write_req,
    output reg  [15:0] o_xmov_addr,
    // interface configuration
    input  wire        i_multiplexed,
    input  wire [1:0]  i_mem_mode,
    // pin claim
    output reg         o_pins_claimed,
    output reg         o_mux_mode,
    output reg  [15:0] o_addr_pin_o,
    output reg  [15:0] o_addr_pin_oe,
    output reg  [7:0]  o_data_pin_o,
    output reg         o_data_pin_oe,
    output reg         o_rd_n_pin,
    output reg         o_wr_n_pin
);
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_OFF  = 2'h2;

    reg  [1:0]  state_r;
    reg  [7:0]  sp_r;
    reg  [15:0] data_pointer_r;
    reg  [7:0]  page_r;
    reg  [7:0]  wreg0 [0:3];
    reg  [7:0]  wreg1 [0:3];
    reg  [15:0] xaddr_r;
    reg         xwrite_r;
    reg         onchip_external_ram_sel_r;
    reg  [2:0]  bitpos_r;
    reg         isbit_r;
    reg  [7:0]  xwdata_r;

    wire [1:0]  bank = {i_program_status_word[`DMADR_PSW_RS_HI],
                        i_program_status_word[`DMADR_PSW_RS_LO]};

    // working register address
    function [7:0] reg_addr;
        input [1:0] bnk;
        input [2:0] num;
        begin
            reg_addr = {3'h0, bnk, num};
        end
    endfunction

    // byte holding a bit address
    function [7:0] bit_byte;
        input [7:0] baddr;
        begin
            bit_byte = `DMADR_BIT_BASE + {4'h0, baddr[6:3]};
        end
    endfunction

    // mirror of working registers 0/1 per bank, kept for pointer lookup
    wire [7:0] int_ptr = i_int_ptr_sel ? wreg1[bank] : wreg0[bank];
    wire [7:0] x_ptr   = i_xmov_ptr_sel ? wreg1[bank] : wreg0[bank];

    // effective internal address
    reg  [7:0] int_ea;
    reg        to_sfr;
    always @*
    begin
        int_ea = i_int_addr;
        to_sfr = 1'b0;
        if (i_int_is_bit)
        begin
            int_ea = bit_byte(i_int_addr);
        end
        else if (i_int_use_reg)
        begin
            int_ea = reg_addr(bank, i_int_reg_num);
        end
        else if (i_int_indirect)
        begin
            int_ea = int_ptr;
        end
        else
        begin
            to_sfr = i_int_addr[`DMADR_UPPER_BIT];
        end
    end

    wire [15:0] xaddr_calc = i_xmov_wide ? data_pointer_r : {page_r, x_ptr};
    wire        x_offchip_addr = xaddr_calc[15:8] != 8'h00;
    reg        x_off;
    always @*
    begin
        case (i_mem_mode)
            `DMADR_MODE_ONCHIP:  x_off = 1'b0;
            `DMADR_MODE_SPLIT:   x_off = x_offchip_addr;
            `DMADR_MODE_SPLITB:  x_off = x_offchip_addr;
            default:             x_off = 1'b1;
        endcase
    end

    wire        start_int  = i_int_req && state_r == ST_IDLE && !to_sfr;
    wire        start_x    = i_xmov_req && state_r == ST_IDLE && !i_int_req;
    wire        flash_x    = start_x && i_xmov_write && i_flash_write_enable;
    wire        onchip_external_ram_x     = start_x && !flash_x && !x_off;
    wire        off_x      = start_x && !flash_x && x_off;
    wire        push_go    = i_push && state_r == ST_IDLE && !i_int_req && !i_xmov_req;
    wire [7:0]  sp_inc     = sp_r + 8'h01;
    wire [7:0]  iram_rdata;
    wire [7:0]  onchip_external_ram_rdata;
    reg  [7:0]  iram_wdata;
    reg         iram_we;
    reg  [7:0]  iram_waddr;

    // bit writes take two cycles: read the byte, then write it back with the bit merged in
    always @*
    begin
        iram_we    = 1'b0;
        iram_waddr = int_ea;
        iram_wdata = i_int_wdata;
        if (push_go)
        begin
            iram_we    = 1'b1;
            iram_waddr = sp_inc;
            iram_wdata = i_push_data;
        end
        else if (state_r == ST_READ && xwrite_r && isbit_r)
        begin
            iram_we    = 1'b1;
            iram_waddr = xaddr_r[7:0];
            iram_wdata = iram_rdata;
            iram_wdata[bitpos_r] = xwdata_r[0];
        end
        else if (start_int && i_int_write && !i_int_is_bit)
        begin
            iram_we = 1'b1;
        end
    end

    dmadr_ram u_iram
    (
        .i_clock (i_clock),
        .i_we    (iram_we),
        .i_waddr (iram_waddr),
        .i_wdata (iram_wdata),
        .i_raddr (start_int ? int_ea : xaddr_r[7:0]),
        .o_rdata (iram_rdata)
    );

    dmadr_ram u_onchip_external_ram
    (
        .i_clock (i_clock),
        .i_we    (onchip_external_ram_x && i_xmov_write),
        .i_waddr (xaddr_calc[7:0]),
        .i_wdata (i_xmov_wdata),
        .i_raddr (xaddr_calc[7:0]),
        .o_rdata (onchip_external_ram_rdata)
    );

    integer k;
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r    <= ST_IDLE;
            sp_r       <= `DMADR_SP_RESET;
            data_pointer_r     <= `DMADR_DATA_POINTER_RESET;
            page_r     <= `DMADR_PAGE_RESET;
            xaddr_r    <= 16'h0000;
            xwrite_r   <= 1'b0;
            onchip_external_ram_sel_r <= 1'b0;
            bitpos_r   <= 3'h0;
            isbit_r    <= 1'b0;
            xwdata_r   <= 8'h00;
            for (k = 0; k < 4; k = k + 1)
            begin
                wreg0[k] <= 8'h00;
                wreg1[k] <= 8'h00;
            end
        end
        else
        begin
            if (i_sp_write)
            begin
                sp_r <= i_sp_wdata;
            end
            else if (push_go)
            begin
                sp_r <= sp_inc;
            end
            if (i_dph_write)
            begin
                data_pointer_r[15:8] <= i_sfr_wdata;
            end
            if (i_dpl_write)
            begin
                data_pointer_r[7:0] <= i_sfr_wdata;
            end
            if (i_page_write)
            begin
                page_r <= i_sfr_wdata;
            end
            // shadow copies of pointer registers track every byte write
            if (iram_we && iram_waddr[7:5] == 3'h0 && iram_waddr[2:1] == 2'h0)
            begin
                if (iram_waddr[0])
                begin
                    wreg1[iram_waddr[4:3]] <= iram_wdata;
                end
                else
                begin
                    wreg0[iram_waddr[4:3]] <= iram_wdata;
                end
            end
            case (state_r)
                ST_IDLE:
                begin
                    if (start_int)
                    begin
                        state_r  <= ST_READ;
                        xaddr_r  <= {8'h00, int_ea};
                        xwrite_r <= i_int_write;
                        isbit_r  <= i_int_is_bit;
                        bitpos_r <= i_int_addr[2:0];
                        xwdata_r <= {7'h00, i_int_bit_wdata};
                    end
                    else if (onchip_external_ram_x)
                    begin
                        state_r    <= ST_READ;
                        onchip_external_ram_sel_r <= 1'b1;
                        isbit_r    <= 1'b0;
                        xwrite_r   <= 1'b0;
                    end
                    else if (off_x)
                    begin
                        state_r  <= ST_OFF;
                        xaddr_r  <= xaddr_calc;
                        xwrite_r <= i_xmov_write;
                        xwdata_r <= i_xmov_wdata;
                    end
                end
                ST_READ:
                begin
                    state_r    <= ST_IDLE;
                    onchip_external_ram_sel_r <= 1'b0;
                end
                ST_OFF:
                begin
                    if (i_xmov_offchip_done)
                    begin
                        state_r <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_int_rdata      <= 8'h00;
            o_int_bit_rdata  <= 1'b0;
            o_int_valid      <= 1'b0;
            o_sfr_req        <= 1'b0;
            o_sfr_write      <= 1'b0;
            o_sfr_addr       <= 8'h00;
            o_sfr_wdata      <= 8'h00;
            o_xmov_rdata     <= 8'h00;
            o_xmov_valid     <= 1'b0;
            o_flash_write_req <= 1'b0;
            o_xmov_addr      <= 16'h0000;
        end
        else
        begin
            o_sfr_req    <= i_int_req && state_r == ST_IDLE && to_sfr;
            o_sfr_write  <= i_int_write;
            o_sfr_addr   <= i_int_addr;
            o_sfr_wdata  <= i_int_wdata;
            o_int_valid  <= state_r == ST_READ && !onchip_external_ram_sel_r;
            o_flash_write_req <= flash_x;
            if (start_x)
            begin
                o_xmov_addr <= xaddr_calc;
            end
            if (state_r == ST_READ && !onchip_external_ram_sel_r)
            begin
                o_int_rdata     <= iram_rdata;
                o_int_bit_rdata <= iram_rdata[bitpos_r];
            end
            o_xmov_valid <= (state_r == ST_READ && onchip_external_ram_sel_r) ||
                            (state_r == ST_OFF && i_xmov_offchip_done) || flash_x;
            if (state_r == ST_READ && onchip_external_ram_sel_r)
            begin
                o_xmov_rdata <= onchip_external_ram_rdata;
            end
            else if (state_r == ST_OFF && i_xmov_offchip_done)
            begin
                o_xmov_rdata <= i_xmov_offchip_rdata;
            end
        end
    end

    // visible copies of the pointer registers
    always @*
    begin
        o_stack_pointer     = sp_r;
        o_data_pointer_high = data_pointer_r[15:8];
        o_data_pointer_low  = data_pointer_r[7:0];
        o_page_select_field = page_r;
    end

    // pins follow the claim; drive type stays with port mode registers
    always @*
    begin
        o_pins_claimed = state_r == ST_OFF;
        o_mux_mode     = i_multiplexed;
        o_addr_pin_o   = xaddr_r;
        o_addr_pin_oe  = {16{o_pins_claimed}};
        o_data_pin_o   = xwdata_r;
        o_data_pin_oe  = o_pins_claimed && xwrite_r;
        o_rd_n_pin     = !(o_pins_claimed && !xwrite_r);
        o_wr_n_pin     = !(o_pins_claimed && xwrite_r);
        if (i_multiplexed && o_pins_claimed && !xwrite_r)
        begin
            o_addr_pin_oe[7:0] = 8'h00;
        end
    end
endmodule // dmadr_top

// file: testbench/dmadr_top_props.sv
`include "dmadr_defs.vh"
module dmadr_chk
(
    // clock, reset and requests
    input wire logic        i_clock, i_rst, i_int_req, i_int_indirect, i_int_is_bit,
    input wire logic        i_int_use_reg, i_push, i_xmov_req, i_xmov_write, i_xmov_wide,
    input wire logic        i_flash_write_enable, i_sp_write, i_page_write, i_dph_write,
    input wire logic        i_xmov_offchip_done, i_multiplexed,
    input wire logic [1:0]  i_mem_mode,
    input wire logic [7:0]  i_int_addr, i_sp_wdata, i_sfr_wdata,
    // design outputs
    input wire logic        o_sfr_req, o_int_valid, o_flash_write_req, o_pins_claimed,
    input wire logic        o_rd_n_pin, o_wr_n_pin, o_data_pin_oe, o_mux_mode,
    input wire logic [7:0]  o_sfr_addr, o_stack_pointer, o_page_select_field,
    input wire logic [7:0]  o_data_pointer_high, o_data_pointer_low,
    input wire logic [15:0] o_xmov_addr, o_addr_pin_oe
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // a direct byte access above the lower half leaves the ram alone
    wire sfr_acc = i_int_req && !i_int_indirect && !i_int_is_bit && !i_int_use_reg
        && i_int_addr[7];

    rst_vals_a: assert property ($fell(i_rst) |-> o_stack_pointer == `DMADR_SP_RESET
        && o_page_select_field == `DMADR_PAGE_RESET) else $error("bad reset values");
    push_inc_a: assert property (i_push && !i_int_req && !i_xmov_req && !$past(i_int_req)
        && !o_pins_claimed |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
        else $error("push did not advance stack pointer");
    sp_load_a: assert property (i_sp_write && !i_push
        |=> o_stack_pointer == $past(i_sp_wdata)) else $error("stack pointer load lost");
    page_load_a: assert property (i_page_write
        |=> o_page_select_field == $past(i_sfr_wdata)) else $error("page select load lost");
    dph_load_a: assert property (i_dph_write |=> o_data_pointer_high == $past(i_sfr_wdata))
        else $error("pointer high load lost");
    sfr_route_a: assert property (sfr_acc |=> o_sfr_req && o_sfr_addr == $past(i_int_addr))
        else $error("direct upper access not routed out");
    byte_answer_a: assert property (i_int_req && !sfr_acc && !$past(i_int_req)
        |-> ##2 o_int_valid) else $error("internal access not answered");
    wide_addr_a: assert property (i_xmov_req && i_xmov_wide
        |-> ##[1:2] o_xmov_addr == {o_data_pointer_high, o_data_pointer_low})
        else $error("wide move address wrong");
    page_addr_a: assert property (i_xmov_req && !i_xmov_wide
        |-> ##[1:2] o_xmov_addr[15:8] == o_page_select_field)
        else $error("paged move high byte wrong");
    flash_req_a: assert property (i_xmov_req && i_xmov_write && i_flash_write_enable
        |=> o_flash_write_req && !o_pins_claimed) else $error("flash write not diverted");
    onchip_pins_a: assert property (i_xmov_req && i_mem_mode == `DMADR_MODE_ONCHIP
        |=> !o_pins_claimed [*2]) else $error("pins claimed for on-chip move");
    offchip_claim_a: assert property (i_xmov_req && i_mem_mode == `DMADR_MODE_OFFCHIP
        && !i_flash_write_enable |=> o_pins_claimed) else $error("off-chip move left pins");
    idle_pins_a: assert property (!o_pins_claimed |-> o_rd_n_pin && o_wr_n_pin && !o_data_pin_oe
        && o_addr_pin_oe == 16'h0000) else $error("pins driven while unclaimed");
    read_float_a: assert property (o_pins_claimed && !o_rd_n_pin |-> !o_data_pin_oe)
        else $error("data drivers on during read");
    pin_return_a: assert property (o_pins_claimed && i_xmov_offchip_done |=> !o_pins_claimed)
        else $error("pins kept after completion");
    mux_sel_a: assert property (o_pins_claimed |-> o_mux_mode == i_multiplexed)
        else $error("pin arrangement wrong");
    cover property (o_pins_claimed && !o_rd_n_pin);
    cover property (o_flash_write_req);
    cover property ($rose(o_sfr_req));
endmodule // dmadr_chk

bind dmadr_top dmadr_chk chk_u (.*);

// file: testbench/dmadr_xmem.sv
module dmadr_xmem
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // pins from the interface
    input  wire logic        i_claim,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_data,
    input  wire logic [3:0]  i_lat,
    // answer
    output logic             o_done,
    output logic [7:0]       o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [3:0] cnt_r;
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_done <= 1'b0;
            cnt_r <= 4'h0;
            o_rdata <= 8'hA5;
        end
        else if (i_claim && !(i_rd_n && i_wr_n) && !o_done)
        begin
            if (cnt_r == i_lat)
            begin
                o_done <= 1'b1;
                cnt_r <= 4'h0;
                if (!i_wr_n)
                    mem[i_addr[7:0]] <= i_data;
                o_rdata <= mem[i_addr[7:0]];
            end
            else
            begin
                cnt_r <= cnt_r + 4'h1;
                o_rdata <= ~o_rdata;
            end
        end
        else
        begin
            // data bus floats outside a read answer: invert the last byte every cycle
            o_done <= 1'b0;
            cnt_r <= 4'h0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule // dmadr_xmem

// file: testbench/dmadr_top_test.sv
`include "dmadr_defs.vh"
module dmadr_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] W = 5'h10, IND = 5'h08, BIT = 5'h04, REG = 5'h02, P1 = 5'h01;
    logic        i_clock, i_rst, i_flash_write_enable, i_int_req, i_int_write, i_int_indirect;
    logic        i_int_is_bit, i_int_use_reg, i_int_ptr_sel, i_int_bit_wdata, i_push, i_sp_write;
    logic        i_dph_write, i_dpl_write, i_page_write, i_xmov_req, i_xmov_write, i_xmov_wide;
    logic        i_xmov_ptr_sel, i_xmov_offchip_done, i_multiplexed;
    logic [1:0]  i_mem_mode;
    logic [2:0]  i_int_reg_num;
    logic [3:0]  lat;
    logic [7:0]  i_program_status_word, i_int_addr, i_int_wdata, i_push_data, i_sp_wdata, v;
    logic [7:0]  i_sfr_wdata, i_xmov_wdata, i_xmov_offchip_rdata, o_int_rdata, o_sfr_addr;
    logic [7:0]  o_sfr_wdata, o_stack_pointer, o_data_pointer_high, o_data_pointer_low;
    logic [7:0]  o_page_select_field, o_xmov_rdata, o_data_pin_o;
    logic        o_int_bit_rdata, o_int_valid, o_sfr_req, o_sfr_write, o_xmov_valid;
    logic        o_flash_write_req, o_pins_claimed, o_mux_mode, o_data_pin_oe;
    logic        o_rd_n_pin, o_wr_n_pin;
    logic [15:0] o_xmov_addr, o_addr_pin_o, o_addr_pin_oe;
    logic [8:0]  n;
    logic [8:0]  int_q [$];
    logic [7:0]  xm_q [$];
    int          fails, check_count, b;

    dmadr_top dut_u (.*);
    dmadr_xmem xmem_u (.i_clock(i_clock), .i_rst(i_rst), .i_claim(o_pins_claimed),
        .i_rd_n(o_rd_n_pin), .i_wr_n(o_wr_n_pin), .i_addr(o_addr_pin_o), .i_data(o_data_pin_o),
        .i_lat(lat), .o_done(i_xmov_offchip_done), .o_rdata(i_xmov_offchip_rdata));

    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic print_verdict();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_for(input logic xm);
        int k;
        for (k = 0; k < 40; k++)
        begin
            @(posedge i_clock);
            if ((xm ? o_xmov_valid : o_int_valid) === 1'b1)
                break;
        end
        if (k == 40)
        begin
            fails++;
            print_verdict();
        end
        @(posedge i_clock);
    endtask

    task automatic iop(input logic [4:0] f, input logic [2:0] rn, input logic [7:0] a,
                       input logic [7:0] wd, input logic [8:0] note, input logic rd);
        @(posedge i_clock);
        {i_int_write, i_int_indirect, i_int_is_bit, i_int_use_reg, i_int_ptr_sel} <= f;
        i_int_req <= 1'b1;
        i_int_reg_num <= rn;
        i_int_addr <= a;
        i_int_wdata <= wd;
        i_int_bit_wdata <= wd[0];
        if (rd)
            int_q.push_back(note);
        @(posedge i_clock);
        i_int_req <= 1'b0;
        if (f[3:1] == 3'b000 && a[7])
        begin
            #1;
            cmp({7'h00, o_sfr_req}, 8'h01);
            cmp(o_sfr_addr, a);
            cmp(o_sfr_wdata, wd);
            cmp({7'h00, o_sfr_write}, {7'h00, f[4]});
        end
        else
            wait_for(1'b0);
    endtask

    task automatic xop(input logic w, input logic wide, input logic ps, input logic [7:0] d,
                       input logic rd);
        @(posedge i_clock);
        i_xmov_req <= 1'b1;
        i_xmov_write <= w;
        i_xmov_wide <= wide;
        i_xmov_ptr_sel <= ps;
        i_xmov_wdata <= d;
        lat <= 4'($urandom_range(3, 0));
        if (rd)
            xm_q.push_back(d);
        @(posedge i_clock);
        i_xmov_req <= 1'b0;
        wait_for(1'b1);
    endtask

    task automatic stk(input logic ld, input logic [7:0] d);
        @(posedge i_clock);
        {i_sp_write, i_push} <= {ld, !ld};
        {i_sp_wdata, i_push_data} <= {d, d};
        @(posedge i_clock);
        {i_sp_write, i_push} <= 2'b00;
        @(posedge i_clock);
    endtask

    task automatic sfrw(input logic [2:0] sel, input logic [7:0] d);
        @(posedge i_clock);
        {i_dph_write, i_dpl_write, i_page_write} <= sel;
        i_sfr_wdata <= d;
        @(posedge i_clock);
        {i_dph_write, i_dpl_write, i_page_write} <= 3'b000;
        #1;
    endtask

    // results arrive in request order, so the oldest note belongs to them
    always @(posedge i_clock)
    begin
        if (o_int_valid === 1'b1 && int_q.size() > 0)
        begin
            n = int_q.pop_front();
            if (n[8])
                cmp({7'h00, o_int_bit_rdata}, n[7:0]);
            else
                cmp(o_int_rdata, n[7:0]);
        end
        if (o_xmov_valid === 1'b1 && xm_q.size() > 0)
            cmp(o_xmov_rdata, xm_q.pop_front());
    end

    initial
    begin
        i_rst = 1'b1;
        {i_flash_write_enable, i_int_req, i_int_write, i_int_indirect, i_int_is_bit} = '0;
        {i_int_use_reg, i_int_ptr_sel, i_int_bit_wdata, i_push, i_sp_write, i_dph_write} = '0;
        {i_dpl_write, i_page_write, i_xmov_req, i_xmov_write, i_xmov_wide, i_xmov_ptr_sel} = '0;
        {i_multiplexed, i_mem_mode, i_int_reg_num, lat, i_program_status_word} = '0;
        {i_int_addr, i_int_wdata, i_push_data, i_sp_wdata, i_sfr_wdata, i_xmov_wdata} = '0;
        {fails, check_count} = '0;
        void'($urandom(32'hBCC4));
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        cmp(o_stack_pointer, 8'h07);
        cmp(o_page_select_field, 8'h00);
        cmp(o_data_pointer_low, 8'h00);
        cmp({7'h00, o_rd_n_pin}, 8'h01);
        v = $urandom;
        stk(1'b0, v);
        cmp(o_stack_pointer, 8'h08);
        iop(0, 0, 8'h08, 0, {1'b0, v}, 1);
        for (b = 0; b < 4; b++)
        begin
            i_program_status_word <= {3'b000, b[1:0], 3'b000};
            v = $urandom;
            iop(W | REG, 3'(b + 3), 0, v, 0, 0);
            iop(0, 0, {3'b000, b[1:0], 3'(b + 3)}, 0, {1'b0, v}, 1);
        end
        v = $urandom;
        iop(W, 0, 8'h22, v, 0, 0);
        for (b = 0; b < 8; b++)
            iop(BIT, 0, 8'(8'h10 + b), 0, {1'b1, 7'h00, v[b]}, 1);
        iop(W | BIT, 0, 8'h13, {7'h00, ~v[3]}, 0, 0);
        iop(0, 0, 8'h22, 0, {1'b0, v ^ 8'h08}, 1);
        i_program_status_word <= 8'h08;
        iop(W | REG, 0, 0, 8'h90, 0, 0);
        iop(W | REG, 1, 0, 8'h45, 0, 0);
        v = $urandom;
        iop(W | IND, 0, 0, v, 0, 0);
        iop(IND, 0, 0, 0, {1'b0, v}, 1);
        iop(0, 0, 8'h90, v, 0, 0);
        iop(W | IND | P1, 0, 0, ~v, 0, 0);
        iop(0, 0, 8'h45, 0, {1'b0, ~v}, 1);
        stk(1'b1, 8'hFE);
        cmp(o_stack_pointer, 8'hFE);
        stk(1'b0, v);
        stk(1'b0, ~v);
        cmp(o_stack_pointer, 8'h00);
        iop(W | REG, 1, 0, 8'hFF, 0, 0);
        iop(IND | P1, 0, 0, 0, {1'b0, v}, 1);
        iop(0, 0, 8'h00, 0, {1'b0, ~v}, 1);
        sfrw(3'b100, 8'h00);
        sfrw(3'b010, 8'h12);
        cmp(o_data_pointer_low, 8'h12);
        xop(1, 1, 0, v, 0);
        xop(0, 1, 0, v, 1);
        iop(W | REG, 1, 0, 8'h12, 0, 0);
        xop(0, 0, 1, v, 1);
        i_flash_write_enable <= 1'b1;
        xop(1, 1, 0, ~v, 0);
        i_flash_write_enable <= 1'b0;
        xop(0, 1, 0, v, 1);
        // pin arrangement first, memory mode second
        i_multiplexed <= 1'b0;
        @(posedge i_clock);
        i_mem_mode <= `DMADR_MODE_OFFCHIP;
        sfrw(3'b100, 8'h12);
        sfrw(3'b010, 8'h34);
        v = $urandom;
        xop(1, 1, 0, v, 0);
        xop(0, 1, 0, v, 1);
        iop(W | REG, 1, 0, 8'h34, 0, 0);
        sfrw(3'b001, 8'h12);
        cmp(o_page_select_field, 8'h12);
        xop(0, 0, 1, v, 1);
        for (b = 1; b < 4; b++)
        begin
            i_mem_mode <= b[1:0];
            xop(0, 1, 0, v, 1);
        end
        i_mem_mode <= `DMADR_MODE_ONCHIP;
        i_multiplexed <= 1'b1;
        repeat (4) @(posedge i_clock);
        if (int_q.size() != 0 || xm_q.size() != 0)
            fails++;
        print_verdict();
    end
endmodule // dmadr_top_test
